//--- common/pulse_loop_pkg.sv
// Constants and pin bundles for the pulse train position loop
package pulse_loop_pkg;

	// Clock and timing
	localparam int CLK_HZ = 50_000_000;
	localparam int READY_DELAY_US = 100_000;
	localparam int READY_DELAY_CYCLES = READY_DELAY_US * (CLK_HZ / 1_000_000);

	// Register map, byte addresses on a 32-bit Avalon slave
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] OFS_INPOS_WIDTH = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_ENC_LINES = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_IN_FSEL = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_OUT_FSEL = 5'h0c;
	localparam logic [ADDR_W-1:0] OFS_DROOP = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h14;

	// Status word bit positions
	localparam int ST_SERVO_ON = 0;
	localparam int ST_READY = 1;
	localparam int ST_INPOS = 2;
	localparam int ST_FWD_LIMIT = 3;
	localparam int ST_REV_LIMIT = 4;

	// Reset values
	localparam logic [31:0] INPOS_WIDTH_RST = 32'h0000_0064;
	localparam logic [15:0] ENC_LINES_RST = 16'h0400;
	localparam logic [31:0] IN_FSEL_RST = 32'h0000_0000;
	localparam logic [31:0] OUT_FSEL_RST = 32'h0000_0000;

	// Terminal function codes
	localparam int FSEL_W = 8;
	localparam logic [FSEL_W-1:0] FSEL_SERVO_ON = 8'h17;
	localparam logic [FSEL_W-1:0] FSEL_IN_POSITION = 8'h24;

	// Encoder position width, four counts per line of a 16-bit line count
	localparam int POS_W = 18;

	// Command pulse and contact pins; high means the contact is shorted to common
	typedef struct packed {
		logic revTravelLimitIn;
		logic fwdTravelLimitIn;
		logic counterClearIn;
		logic revCmdPulseIn;
		logic fwdCmdPulseIn;
	} cmdPins_s;

	// Quadrature encoder channels
	typedef struct packed {
		logic b;
		logic a;
	} encPins_s;

endpackage

//--- rtl/pulse_train_position_loop.sv
// Position loop: deviation counter, servo enable, ready, in-position, index
`timescale 1ns/1ns
`default_nettype none

module pulse_train_position_loop #(
	parameter int CNT_W = 24,
	parameter int NUM_IN = 4,
	parameter int NUM_OUT = 4,
	parameter int READY_DELAY = pulse_loop_pkg::READY_DELAY_CYCLES
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Avalon-MM slave
	input wire logic [pulse_loop_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Pins from controller, contacts and encoder
	input wire pulse_loop_pkg::cmdPins_s cmdPins,
	input wire pulse_loop_pkg::encPins_s encPins,
	input wire logic [NUM_IN-1:0] termIn,
	// Drive side
	output logic baseEnable,
	output logic driveReady,
	output logic signed [CNT_W-1:0] speedCmd,
	output logic indexRevOut,
	output logic [NUM_OUT-1:0] termOut
);
	import pulse_loop_pkg::*;

	localparam int SYNC_W = 7 + NUM_IN;

	if (NUM_IN < 1 || NUM_IN > 4 || NUM_OUT < 1 || NUM_OUT > 4)
		$error("Terminal counts must be 1 to 4");
	if (CNT_W < 8 || CNT_W > 32)
		$error("Counter width must be 8 to 32");
	if (READY_DELAY < 1)
		$error("Ready delay must be at least one cycle");

	////////////////////////////////////////////////////////////////////////////
	// Functions

	// Clamp a wide sum into the counter range
	function automatic logic signed [CNT_W-1:0] saturate(input logic signed [CNT_W+1:0] v);
		logic signed [CNT_W+1:0] maxV;
		logic signed [CNT_W+1:0] minV;
		maxV = (CNT_W+2)'((64'sd1 <<< (CNT_W-1)) - 64'sd1);
		minV = -maxV - (CNT_W+2)'(1);
		if (v > maxV)
			saturate = maxV[CNT_W-1:0];
		else if (v < minV)
			saturate = minV[CNT_W-1:0];
		else
			saturate = v[CNT_W-1:0];
	endfunction

	// One quadrature step: +1 with A leading, -1 with B leading
	function automatic logic signed [1:0] quadStep(input logic [1:0] prevBa, input logic [1:0] curBa);
		case ({prevBa, curBa})
			4'b0001, 4'b0111, 4'b1110, 4'b1000: quadStep = 2'sd1;
			4'b0010, 4'b1011, 4'b1101, 4'b0100: quadStep = -2'sd1;
			default: quadStep = 2'sd0;
		endcase
	endfunction

	// Byte-lane merge of a bus write
	function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				r[8*i +: 8] = wd[8*i +: 8];
		end
		mergeBytes = r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge history

	logic [SYNC_W-1:0] meta_ff, sync_ff, prev_ff;
	logic [SYNC_W-1:0] nxt_meta, nxt_sync, nxt_prev;

	always_comb
	begin
		nxt_meta = {termIn, encPins, cmdPins};
		nxt_sync = meta_ff;
		nxt_prev = sync_ff;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
			prev_ff <= '0;
		end
		else
		begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
			prev_ff <= nxt_prev;
		end
	end

	cmdPins_s cmdNow, cmdOld;
	encPins_s encNow, encOld;
	logic [NUM_IN-1:0] termNow;
	assign cmdNow = sync_ff[4:0];
	assign cmdOld = prev_ff[4:0];
	assign encNow = sync_ff[6:5];
	assign encOld = prev_ff[6:5];
	assign termNow = sync_ff[SYNC_W-1:7];

	////////////////////////////////////////////////////////////////////////////
	// Registers reached over the bus

	logic ack_ff, nxt_ack;
	logic [31:0] readdata_ff, nxt_readdata;
	logic [31:0] inposWidthSetting_ff, nxt_inposWidthSetting;
	logic [15:0] encLines_ff, nxt_encLines;
	logic [31:0] inputFunctionSelect_ff, nxt_inputFunctionSelect;
	logic [31:0] outputFunctionSelect_ff, nxt_outputFunctionSelect;
	logic signed [CNT_W-1:0] droop_ff;
	logic [31:0] statusWord;
	logic servoOn, inPos_ff, ready_ff;
	logic [31:0] encLinesWide;

	// One wait state per access; unmapped reads give zero, writes drop
	assign waitrequest = (read | write) & ~ack_ff;
	assign readdata = readdata_ff;
	assign encLinesWide = mergeBytes({16'h0000, encLines_ff}, writedata, byteenable);

	always_comb
	begin
		statusWord = '0;
		statusWord[ST_SERVO_ON] = servoOn;
		statusWord[ST_READY] = ready_ff;
		statusWord[ST_INPOS] = inPos_ff;
		statusWord[ST_FWD_LIMIT] = cmdNow.fwdTravelLimitIn;
		statusWord[ST_REV_LIMIT] = cmdNow.revTravelLimitIn;
		nxt_ack = (read | write) & ~ack_ff;
		nxt_readdata = readdata_ff;
		nxt_inposWidthSetting = inposWidthSetting_ff;
		nxt_encLines = encLines_ff;
		nxt_inputFunctionSelect = inputFunctionSelect_ff;
		nxt_outputFunctionSelect = outputFunctionSelect_ff;
		if (read && !ack_ff)
		begin
			case (address)
				OFS_INPOS_WIDTH: nxt_readdata = inposWidthSetting_ff;
				OFS_ENC_LINES: nxt_readdata = {16'h0000, encLines_ff};
				OFS_IN_FSEL: nxt_readdata = inputFunctionSelect_ff;
				OFS_OUT_FSEL: nxt_readdata = outputFunctionSelect_ff;
				OFS_DROOP: nxt_readdata = 32'(droop_ff);
				OFS_STATUS: nxt_readdata = statusWord;
				default: nxt_readdata = '0;
			endcase
		end
		if (write && ack_ff)
		begin
			case (address)
				OFS_INPOS_WIDTH:
					nxt_inposWidthSetting = mergeBytes(inposWidthSetting_ff, writedata, byteenable);
				OFS_ENC_LINES: nxt_encLines = encLinesWide[15:0];
				OFS_IN_FSEL:
					nxt_inputFunctionSelect = mergeBytes(inputFunctionSelect_ff, writedata, byteenable);
				OFS_OUT_FSEL:
					nxt_outputFunctionSelect = mergeBytes(outputFunctionSelect_ff, writedata, byteenable);
				default: nxt_ack = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ack_ff <= 1'b0;
			readdata_ff <= '0;
			inposWidthSetting_ff <= INPOS_WIDTH_RST;
			encLines_ff <= ENC_LINES_RST;
			inputFunctionSelect_ff <= IN_FSEL_RST;
			outputFunctionSelect_ff <= OUT_FSEL_RST;
		end
		else
		begin
			ack_ff <= nxt_ack;
			readdata_ff <= nxt_readdata;
			inposWidthSetting_ff <= nxt_inposWidthSetting;
			encLines_ff <= nxt_encLines;
			inputFunctionSelect_ff <= nxt_inputFunctionSelect;
			outputFunctionSelect_ff <= nxt_outputFunctionSelect;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Servo enable and ready delay

	logic [31:0] readyCnt_ff, nxt_readyCnt;
	logic nxt_ready;

	always_comb
	begin
		servoOn = 1'b0;
		for (int i = 0; i < NUM_IN; i++)
		begin
			if (inputFunctionSelect_ff[FSEL_W*i +: FSEL_W] == FSEL_SERVO_ON && termNow[i])
				servoOn = 1'b1;
		end
		nxt_readyCnt = readyCnt_ff;
		nxt_ready = 1'b0;
		if (!servoOn)
			nxt_readyCnt = '0;
		else if (readyCnt_ff < 32'(READY_DELAY))
			nxt_readyCnt = readyCnt_ff + 32'h0000_0001;
		if (servoOn && readyCnt_ff >= 32'(READY_DELAY))
			nxt_ready = 1'b1;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			readyCnt_ff <= '0;
			ready_ff <= 1'b0;
		end
		else
		begin
			readyCnt_ff <= nxt_readyCnt;
			ready_ff <= nxt_ready;
		end
	end

	assign baseEnable = servoOn;
	assign driveReady = ready_ff;

	////////////////////////////////////////////////////////////////////////////
	// Deviation counter and speed command

	logic signed [CNT_W-1:0] nxt_droop, speedCmd_ff, nxt_speedCmd;
	logic signed [CNT_W+1:0] droopSum;
	logic signed [1:0] fbStep;
	logic [CNT_W-1:0] droopMag;
	logic nxt_inPos;

	// Index channel never enters this loop
	assign fbStep = quadStep(encOld, encNow);

	always_comb
	begin
		droopSum = (CNT_W+2)'(droop_ff);
		if (cmdNow.fwdCmdPulseIn && !cmdOld.fwdCmdPulseIn)
			droopSum = droopSum + (CNT_W+2)'(1);
		if (cmdNow.revCmdPulseIn && !cmdOld.revCmdPulseIn)
			droopSum = droopSum - (CNT_W+2)'(1);
		droopSum = droopSum - (CNT_W+2)'(fbStep);
		nxt_droop = saturate(droopSum);
		if (!cmdNow.counterClearIn && cmdOld.counterClearIn)
			nxt_droop = '0;
		droopMag = droop_ff[CNT_W-1] ? CNT_W'(-droop_ff) : CNT_W'(droop_ff);
		nxt_inPos = servoOn && (32'(droopMag) < inposWidthSetting_ff);
		// Proportional speed command; an open limit blocks only its own direction
		nxt_speedCmd = droop_ff;
		if (!servoOn)
			nxt_speedCmd = '0;
		else if (droop_ff > 0 && !cmdNow.fwdTravelLimitIn)
			nxt_speedCmd = '0;
		else if (droop_ff < 0 && !cmdNow.revTravelLimitIn)
			nxt_speedCmd = '0;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			droop_ff <= '0;
			speedCmd_ff <= '0;
			inPos_ff <= 1'b0;
		end
		else
		begin
			droop_ff <= nxt_droop;
			speedCmd_ff <= nxt_speedCmd;
			inPos_ff <= nxt_inPos;
		end
	end

	assign speedCmd = speedCmd_ff;

	////////////////////////////////////////////////////////////////////////////
	// Output terminals and index pulse

	logic [NUM_OUT-1:0] termOut_ff, nxt_termOut;
	logic [POS_W-1:0] pos_ff, nxt_pos, revCounts;
	logic index_ff, nxt_index;

	assign revCounts = {encLines_ff, 2'b00};

	always_comb
	begin
		for (int j = 0; j < NUM_OUT; j++)
			nxt_termOut[j] = (outputFunctionSelect_ff[FSEL_W*j +: FSEL_W] == FSEL_IN_POSITION)
				&& inPos_ff;
		nxt_pos = pos_ff;
		nxt_index = 1'b0;
		// Zero line count disables the index rather than pulsing every step
		if (revCounts != '0 && fbStep == 2'sd1)
		begin
			if (pos_ff >= revCounts - POS_W'(1))
			begin
				nxt_pos = '0;
				nxt_index = 1'b1;
			end
			else
				nxt_pos = pos_ff + POS_W'(1);
		end
		else if (revCounts != '0 && fbStep == -2'sd1)
		begin
			if (pos_ff == '0 || pos_ff >= revCounts)
			begin
				nxt_pos = revCounts - POS_W'(1);
				nxt_index = 1'b1;
			end
			else
				nxt_pos = pos_ff - POS_W'(1);
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			termOut_ff <= '0;
			pos_ff <= '0;
			index_ff <= 1'b0;
		end
		else
		begin
			termOut_ff <= nxt_termOut;
			pos_ff <= nxt_pos;
			index_ff <= nxt_index;
		end
	end

	assign termOut = termOut_ff;
	assign indexRevOut = index_ff;

endmodule

`default_nettype wire

//--- testbench/pulse_loop_monitor.sv
// Port checker for the pulse train position loop
`timescale 1ns/1ns
`default_nettype none
module pulse_loop_monitor #(
	parameter int CNT_W = 24,
	parameter int NUM_OUT = 4,
	parameter int READY_DELAY = 20
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Pins and drive side
	input wire pulse_loop_pkg::cmdPins_s cmdPins,
	input wire logic baseEnable,
	input wire logic driveReady,
	input wire logic signed [CNT_W-1:0] speedCmd,
	input wire logic indexRevOut,
	input wire logic [NUM_OUT-1:0] termOut
);
	import pulse_loop_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////
	// Saturating count of servo-on cycles, so long delays need no long repetition
	int onCnt_ff;
	int nxt_onCnt;
	always_comb
	begin
		nxt_onCnt = baseEnable ? ((onCnt_ff < READY_DELAY + 8) ? onCnt_ff + 1 : onCnt_ff) : 0;
	end
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			onCnt_ff <= 0;
		else
			onCnt_ff <= nxt_onCnt;
	end
	AST_READY_DELAY:
	assert property ($rose(driveReady) |-> onCnt_ff >= READY_DELAY - 1 && onCnt_ff <= READY_DELAY + 1)
		else $error("ready rose at wrong delay");
	AST_READY_BY:
	assert property (baseEnable && onCnt_ff == READY_DELAY + 3 |-> driveReady)
		else $error("ready missing after delay");
	AST_READY_OFF:
	assert property ((!baseEnable) [*2] |-> !driveReady)
		else $error("ready while power stage off");
	AST_STOP_OFF:
	assert property ((!baseEnable) [*2] |-> speedCmd == 0)
		else $error("speed command while power stage off");
	AST_FWD_INHIBIT:
	assert property ((!cmdPins.fwdTravelLimitIn) [*5] |-> speedCmd <= 0)
		else $error("forward speed with forward limit open");
	AST_REV_INHIBIT:
	assert property ((!cmdPins.revTravelLimitIn) [*5] |-> speedCmd >= 0)
		else $error("reverse speed with reverse limit open");
	AST_INPOS_OFF:
	assert property ((!baseEnable) [*3] |-> termOut == '0)
		else $error("in-position output while servo off");
	AST_INDEX_PULSE:
	assert property (indexRevOut |=> !indexRevOut)
		else $error("index pulse longer than one cycle");
endmodule
bind pulse_train_position_loop pulse_loop_monitor #(.CNT_W(CNT_W), .NUM_OUT(NUM_OUT),
	.READY_DELAY(READY_DELAY)) u_mon (.clk(clk), .arst_n(arst_n), .cmdPins(cmdPins),
	.baseEnable(baseEnable), .driveReady(driveReady), .speedCmd(speedCmd),
	.indexRevOut(indexRevOut), .termOut(termOut));
`default_nettype wire

//--- testbench/pulse_controller_model.sv
// Behavioural positioning controller emitting command pulse trains
`timescale 1ns/1ns
`default_nettype none
module pulse_controller_model
(
	// Clock
	input wire logic clk,
	// Pulse lines, idle low so no stray count
	output logic fwdPulse,
	output logic revPulse
);
	initial
	begin
		fwdPulse = 1'b0;
		revPulse = 1'b0;
	end
	////////////////////////////////////////
	// Half period of 1 or more cycles; narrower pulses may be missed by the sync
	task automatic send(input int n, input bit fwd, input int half);
		for (int i = 0; i < n; i++)
		begin
			repeat (half) @(posedge clk);
			fwdPulse <= fwd;
			revPulse <= !fwd;
			repeat (half) @(posedge clk);
			fwdPulse <= 1'b0;
			revPulse <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the pulse train position loop
`timescale 1ns/1ns
`default_nettype none
module tb;
	import pulse_loop_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [ADDR_W-1:0] address = '0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = '0;
	logic [3:0] byteenable = 4'hf;
	logic [31:0] readdata;
	logic waitrequest;
	logic fwdP;
	logic revP;
	logic clr = 1'b0;
	logic fwdLim = 1'b1;
	logic revLim = 1'b1;
	cmdPins_s cmdPins;
	encPins_s encPins = '0;
	logic [3:0] termIn = '0;
	logic baseEnable;
	logic driveReady;
	logic indexRevOut;
	logic signed [23:0] speedCmd;
	logic [3:0] termOut;
	logic [31:0] expQ[$];
	int n_fail = 0;
	int samples_checked = 0;
	int seed = 29892;
	int droopExp = 0;
	int idxCnt = 0;
	int ph = 0;
	int n;
	assign cmdPins = '{revLim, fwdLim, clr, revP, fwdP};
	always #10 clk = ~clk;
	pulse_controller_model u_ctl (.clk(clk), .fwdPulse(fwdP), .revPulse(revP));
	pulse_train_position_loop #(.READY_DELAY(20)) u_dut (.clk(clk), .arst_n(arst_n),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
		.cmdPins(cmdPins), .encPins(encPins), .termIn(termIn), .baseEnable(baseEnable),
		.driveReady(driveReady), .speedCmd(speedCmd), .indexRevOut(indexRevOut),
		.termOut(termOut));
	////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", name, want, seen);
		end
	endtask
	// Request stands until waitrequest is seen low at a rising edge; only the watchdog ends a hang
	task automatic bus(input logic [ADDR_W-1:0] a, input bit wr, input logic [31:0] d);
		@(posedge clk);
		address <= a;
		writedata <= d;
		read <= !wr;
		write <= wr;
		@(posedge clk);
		while (waitrequest !== 1'b0)
			@(posedge clk);
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		expQ.push_back(e);
		bus(a, 1'b0, '0);
	endtask
	task automatic enc(input int k, input bit fwd);
		for (int i = 0; i < k; i++)
		begin
			repeat (4) @(posedge clk);
			ph = fwd ? ph + 1 : ph + 3;
			encPins <= (ph % 4 == 0) ? 2'b00 : (ph % 4 == 1) ? 2'b01 : (ph % 4 == 2) ? 2'b11 : 2'b10;
		end
	endtask
	task automatic settle;
		repeat (10) @(posedge clk);
	endtask
	task automatic report_and_stop;
		// A read whose answer never came is a failure too
		if (expQ.size() != 0)
			n_fail++;
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk)
	begin
		if (read === 1'b1 && waitrequest === 1'b0 && expQ.size() > 0)
			check("readdata", readdata, expQ.pop_front());
		if (indexRevOut === 1'b1)
			idxCnt++;
	end
	initial
	begin
		#400000;
		n_fail++;
		report_and_stop;
	end
	initial
	begin
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		rd(OFS_INPOS_WIDTH, INPOS_WIDTH_RST);
		rd(OFS_ENC_LINES, 32'(ENC_LINES_RST));
		rd(OFS_IN_FSEL, IN_FSEL_RST);
		rd(OFS_OUT_FSEL, OUT_FSEL_RST);
		rd(5'h18, 32'h0);
		termIn <= 4'h1;
		settle;
		check("base", 32'(baseEnable), 32'h0);
		bus(OFS_ENC_LINES, 1'b1, 32'h2);
		bus(OFS_OUT_FSEL, 1'b1, 32'(FSEL_IN_POSITION));
		bus(OFS_INPOS_WIDTH, 1'b1, 32'h5);
		bus(OFS_IN_FSEL, 1'b1, 32'(FSEL_SERVO_ON));
		settle;
		check("base", 32'(baseEnable), 32'h1);
		check("rdy", 32'(driveReady), 32'h0);
		repeat (20) @(posedge clk);
		check("rdy", 32'(driveReady), 32'h1);
		rd(OFS_STATUS, 32'h0000_001f);
		u_ctl.send(10, 1'b1, 3);
		droopExp = 10;
		settle;
		rd(OFS_DROOP, 32'(droopExp));
		check("spd", 32'(speedCmd), 32'(droopExp));
		check("tout", 32'(termOut), 32'h0);
		enc(10, 1'b1);
		droopExp = 0;
		settle;
		rd(OFS_DROOP, 32'(droopExp));
		check("spd", 32'(speedCmd), 32'h0);
		check("tout", 32'(termOut), 32'h1);
		u_ctl.send(3, 1'b0, 6);
		droopExp = -3;
		settle;
		check("spd", 32'(speedCmd), 32'(droopExp));
		check("tout", 32'(termOut), 32'h1);
		enc(2, 1'b0);
		droopExp = -1;
		settle;
		rd(OFS_DROOP, 32'(droopExp));
		n = 1 + ($unsigned($random(seed)) % 15);
		u_ctl.send(n, 1'b1, 3);
		droopExp += n;
		settle;
		rd(OFS_DROOP, 32'(droopExp));
		clr <= 1'b1;
		settle;
		rd(OFS_DROOP, 32'(droopExp));
		clr <= 1'b0;
		droopExp = 0;
		settle;
		rd(OFS_DROOP, 32'(droopExp));
		fwdLim <= 1'b0;
		u_ctl.send(4, 1'b1, 3);
		droopExp = 4;
		settle;
		check("spd", 32'(speedCmd), 32'h0);
		fwdLim <= 1'b1;
		revLim <= 1'b0;
		settle;
		check("spd", 32'(speedCmd), 32'(droopExp));
		revLim <= 1'b1;
		idxCnt = 0;
		enc(16, 1'b1);
		droopExp -= 16;
		settle;
		check("idx", 32'(idxCnt), 32'h2);
		rd(OFS_DROOP, 32'(droopExp));
		termIn <= 4'h0;
		settle;
		check("base", 32'(baseEnable), 32'h0);
		check("spd", 32'(speedCmd), 32'h0);
		check("tout", 32'(termOut), 32'h0);
		report_and_stop;
	end
endmodule
`default_nettype wire
